/* cache_enum_pkg.sv */
/*
 * Shared constants for the cache parameter enumerator and its query side.
 * Assumes a single clock domain and that both ends import this package.
 */
package cache_enum_pkg;

	// ----------------------------------------------------------------
	// Descriptor field layout, first word
	// ----------------------------------------------------------------
	localparam int TYPE_LSB      = 0;
	localparam int TYPE_W        = 5;
	localparam int LEVEL_LSB     = 5;
	localparam int LEVEL_W       = 3;
	localparam int SELF_INIT_BIT = 8;
	localparam int FULL_ASSOC_BIT = 9;
	localparam int SHARE_LSB     = 14;
	localparam int SHARE_W       = 12;
	localparam int CORES_LSB     = 26;
	localparam int CORES_W       = 6;

	// ----------------------------------------------------------------
	// Descriptor field layout, second word
	// ----------------------------------------------------------------
	localparam int LINE_LSB      = 0;
	localparam int LINE_W        = 12;
	localparam int PART_LSB      = 12;
	localparam int PART_W        = 10;
	localparam int WAYS_LSB      = 22;
	localparam int WAYS_W        = 10;

	// ----------------------------------------------------------------
	// Cache types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		CT_NULL    = 5'h00,
		CT_DATA    = 5'h01,
		CT_INSTR   = 5'h02,
		CT_UNIFIED = 5'h03
	} cache_kind_type;

	// ----------------------------------------------------------------
	// Leaf visibility, control and stride
	// ----------------------------------------------------------------
	localparam logic [31:0] LEAF_LOW_LIMIT  = 32'h0000_0003;
	localparam logic [31:0] LEAF_HIGH_LIMIT = 32'h8000_0000;
	localparam logic [31:0] LEAF_CACHE      = 32'h0000_0004;
	localparam int          LEAF_LIMIT_BIT  = 22;
	localparam logic [31:0] MISC_RESET      = 32'h0000_0000;
	localparam int          NUM_CACHES      = 4;
	localparam logic [7:0]  LEGACY_PF_64    = 8'hF0;
	localparam logic [7:0]  LEGACY_PF_128   = 8'hF1;
	localparam logic [11:0] STRIDE_DEFAULT  = 12'h040;
	localparam logic [11:0] STRIDE_128      = 12'h080;
	localparam logic [11:0] STRIDE_LEGACY   = 12'h020;
	localparam logic [11:0] STRIDE_NONE     = 12'h000;

	// ----------------------------------------------------------------
	// Query side APB register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_INDEX  = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_WORD0  = 12'h00C;
	localparam logic [11:0] OFF_WORD1  = 12'h010;
	localparam logic [11:0] OFF_WORD2  = 12'h014;
	localparam logic [11:0] OFF_WORD3  = 12'h018;
	localparam logic [11:0] OFF_STRIDE = 12'h01C;
	localparam logic [11:0] OFF_MISC   = 12'h020;
	localparam logic [11:0] OFF_LEAF   = 12'h024;

	typedef enum logic [1:0] {
		Q_IDLE = 2'b00,
		Q_ASK  = 2'b01,
		Q_WAIT = 2'b11
	} query_state_type;

endpackage : cache_enum_pkg

/* cache_query_if.sv */
/*
 * Link between the query side and the cache parameter enumerator.
 * Assumes both ends share pclk; one request is in flight at a time.
 */
`timescale 1ns/10ps
`default_nettype none
interface cache_query_if;
	logic        req;       // One-cycle query strobe
	logic [31:0] leaf;      // Leaf number
	logic [31:0] index;     // Zero-based cache index
	logic        ack;       // One-cycle answer strobe
	logic        visible;   // Leaf not hidden by the limit bit
	logic [31:0] word0;
	logic [31:0] word1;
	logic [31:0] word2;
	logic [31:0] word3;
	logic [11:0] pf_stride; // Reported prefetch stride, zero if none
	logic [31:0] misc_en;   // Miscellaneous enable register image
	logic        misc_we;   // One-cycle write strobe for misc_en

	modport device (
		input  req, leaf, index, misc_en, misc_we,
		output ack, visible, word0, word1, word2, word3, pf_stride
	);
	modport host (
		output req, leaf, index, misc_en, misc_we,
		input  ack, visible, word0, word1, word2, word3, pf_stride
	);
endinterface : cache_query_if
`default_nettype wire

/* cache_param_enum.sv */
/*
 * Cache parameter enumerator: answers one descriptor per cache index.
 * Assumes the query side holds no more than one request in flight.
 */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - zero-based index selects described cache
// - type in word0 bits 4:0
// - level, self-init, fully-assoc bits in word0
// - sharing processors count minus one
// - cores per package minus one
// - line, partitions, ways, sets minus one
// - leaves 4..7FFFFFFF hidden when limit bit set
// - descriptor stride used only for data/unified
// - zero stride means 64 bytes
// - legacy F0 64, F1 128 bytes
// - no mechanism means 32 bytes
// - line size is not the stride
module cache_param_enum
	import cache_enum_pkg::*;
(
	input  wire logic     pclk,
	input  wire logic     presetn,
	input  wire logic     clk_en,
	cache_query_if.device link
);

	// ----------------------------------------------------------------
	// Geometry of this core in true counts; an example set only
	// ----------------------------------------------------------------
	// Entries: L1 data, L1 instruction, L2 unified, terminator
	localparam logic [4:0]  KIND [NUM_CACHES] = '{
		CT_DATA,
		CT_INSTR,
		CT_UNIFIED,
		CT_NULL
	};

	localparam logic [2:0]  LEVEL [NUM_CACHES] = '{ // Numbered from one
		3'h1,
		3'h1,
		3'h2,
		3'h0
	};

	localparam logic        SELF_INIT [NUM_CACHES] = '{ // No soft init
		1'b1,
		1'b1,
		1'b1,
		1'b0
	};

	localparam logic        FULL_ASSOC [NUM_CACHES] = '{ // All set based
		1'b0,
		1'b0,
		1'b0,
		1'b0
	};

	localparam logic [31:0] SHARERS [NUM_CACHES] = '{ // Logical sharers
		32'h0000_0002,
		32'h0000_0002,
		32'h0000_0002,
		32'h0000_0000
	};

	localparam logic [31:0] CORES [NUM_CACHES] = '{ // Cores in package
		32'h0000_0002,
		32'h0000_0002,
		32'h0000_0002,
		32'h0000_0000
	};

	localparam logic [31:0] LINE_BYTES [NUM_CACHES] = '{
		32'h0000_0040,
		32'h0000_0040,
		32'h0000_0040,
		32'h0000_0000
	};

	localparam logic [31:0] PARTS [NUM_CACHES] = '{
		32'h0000_0001,
		32'h0000_0001,
		32'h0000_0001,
		32'h0000_0000
	};

	localparam logic [31:0] WAYS [NUM_CACHES] = '{
		32'h0000_0008,
		32'h0000_0008,
		32'h0000_0010,
		32'h0000_0000
	};

	localparam logic [31:0] SETS [NUM_CACHES] = '{
		32'h0000_0040,
		32'h0000_0040,
		32'h0000_1000,
		32'h0000_0000
	};

	localparam logic [11:0] PF_STRIDE [NUM_CACHES] = '{ // Zero: none given
		STRIDE_NONE,
		STRIDE_NONE,
		STRIDE_128,
		STRIDE_NONE
	};

	// ----------------------------------------------------------------
	// Descriptor words, every live count stored minus one
	// ----------------------------------------------------------------
	logic [31:0] tab_w0 [NUM_CACHES];
	logic [31:0] tab_w1 [NUM_CACHES];
	logic [31:0] tab_w2 [NUM_CACHES];
	logic [11:0] tab_pf [NUM_CACHES];

	for (genvar g = 0; g < NUM_CACHES; g++) begin : g_entry
		// Terminator stays all zero, never wraps to ones
		wire        live    = (KIND[g] != CT_NULL);
		wire [31:0] bias    = live ? 32'h0000_0001 : 32'h0000_0000;
		wire [31:0] share_e = SHARERS[g] - bias;
		wire [31:0] cores_e = CORES[g] - bias;
		wire [31:0] line_e  = LINE_BYTES[g] - bias;
		wire [31:0] part_e  = PARTS[g] - bias;
		wire [31:0] ways_e  = WAYS[g] - bias;
		wire [31:0] sets_e  = SETS[g] - bias;

		// Word 0: cores, sharers, reserved, flags, level, type
		assign tab_w0[g] = {cores_e[CORES_W-1:0],
		                    share_e[SHARE_W-1:0],
		                    4'h0,
		                    FULL_ASSOC[g],
		                    SELF_INIT[g],
		                    LEVEL[g],
		                    KIND[g]};
		// Word 1: ways, partitions, line bytes
		assign tab_w1[g] = {ways_e[WAYS_W-1:0],
		                    part_e[PART_W-1:0],
		                    line_e[LINE_W-1:0]};
		// Word 2: sets
		assign tab_w2[g] = sets_e;
		// Stride kept apart from the line size
		assign tab_pf[g] = PF_STRIDE[g];
	end

	// ----------------------------------------------------------------
	// Decode of request
	// ----------------------------------------------------------------
	logic [31:0] misc_q;
	wire         limit_set = misc_q[LEAF_LIMIT_BIT];
	wire         mid_leaf  = (link.leaf > LEAF_LOW_LIMIT) &&
	                         (link.leaf < LEAF_HIGH_LIMIT);
	wire         leaf_vis  = !(mid_leaf && limit_set);
	wire         is_cache  = (link.leaf == LEAF_CACHE);
	// Index past table holds the null entry for ever
	wire         in_range  = (link.index < NUM_CACHES);
	wire [1:0]   sel       = in_range ? link.index[1:0] : 2'd3;
	wire         hit       = leaf_vis && is_cache;
	wire [31:0]  w0_d      = hit ? tab_w0[sel] : 32'h0000_0000;
	wire [31:0]  w1_d      = hit ? tab_w1[sel] : 32'h0000_0000;
	wire [31:0]  w2_d      = hit ? tab_w2[sel] : 32'h0000_0000;
	wire [11:0]  pf_d      = hit ? tab_pf[sel] : STRIDE_NONE;

	// ----------------------------------------------------------------
	// Control register, limit bit clear after reset
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc_q <= MISC_RESET;
		end else if (clk_en && link.misc_we) begin
			misc_q <= link.misc_en;
		end
	end

	// ----------------------------------------------------------------
	// Registered answer, one cycle after the strobe
	// ----------------------------------------------------------------
	logic        ack_q;
	logic        vis_q;
	logic [31:0] w0_q;
	logic [31:0] w1_q;
	logic [31:0] w2_q;
	logic [11:0] pf_q;

	// Answer strobe follows the request by exactly one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= 1'b0;
		end else if (clk_en) begin
			ack_q <= link.req;
		end
	end

	// Words load with the strobe, then hold until the next request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vis_q <= 1'b0;
			w0_q  <= 32'h0000_0000;
			w1_q  <= 32'h0000_0000;
			w2_q  <= 32'h0000_0000;
			pf_q  <= STRIDE_NONE;
		end else if (clk_en && link.req) begin
			vis_q <= leaf_vis;
			w0_q  <= w0_d;
			w1_q  <= w1_d;
			w2_q  <= w2_d;
			pf_q  <= pf_d;
		end
	end

	assign link.ack       = ack_q;
	assign link.visible   = vis_q;
	assign link.word0     = w0_q;
	assign link.word1     = w1_q;
	assign link.word2     = w2_q;
	assign link.word3     = 32'h0000_0000;
	assign link.pf_stride = pf_q;

endmodule : cache_param_enum
`default_nettype wire

/* cache_query_host.sv */
/*
 * Query side: APB slave that issues enumeration queries and works out
 * the prefetch stride. Assumes the enumerator answers each strobe.
 */
`timescale 1ns/10ps
`default_nettype none
module cache_query_host
	import cache_enum_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	cache_query_if.host      link
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	query_state_type st_q;
	logic [31:0] index_q;
	logic [31:0] leaf_q;
	logic [31:0] misc_q;
	logic        misc_we_q;
	logic        det_q;        // Ctrl bit1: descriptor mechanism present
	logic [7:0]  legacy_q;     // Ctrl bits 15:8: legacy descriptor code
	logic        done_q;
	logic        vis_q;
	logic [31:0] w_q [4];
	logic [11:0] stride_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire setup  = psel && !penable;
	// Writes land only at the edge that completes the access phase
	wire acc    = psel && penable && pready_q;
	wire wr     = acc && pwrite;
	wire go     = wr && (paddr == OFF_CTRL) && pwdata[0];
	wire known  = (paddr <= OFF_LEAF) && (paddr[1:0] == 2'b00);

	// Stride choice by mechanism, line size never consulted
	wire [4:0]  kind_new   = link.word0[TYPE_LSB +: TYPE_W];
	wire        pf_ok_new  = (kind_new == CT_DATA) ||
	                         (kind_new == CT_UNIFIED);
	wire [11:0] leg_stride = (legacy_q == LEGACY_PF_64)  ? STRIDE_DEFAULT :
	                         (legacy_q == LEGACY_PF_128) ? STRIDE_128 :
	                         STRIDE_LEGACY;
	wire [11:0] det_stride = (link.pf_stride == STRIDE_NONE) ?
	                         STRIDE_DEFAULT : link.pf_stride;
	wire [11:0] stride_d   = !det_q ? leg_stride :
	                         (link.visible && pf_ok_new) ? det_stride :
	                         STRIDE_NONE;

	wire [31:0] rd_mux =
		(paddr == OFF_CTRL)   ? {16'h0000, legacy_q, 6'h00, det_q, 1'b0} :
		(paddr == OFF_INDEX)  ? index_q :
		(paddr == OFF_STATUS) ? {29'h0, vis_q, done_q, st_q != Q_IDLE} :
		(paddr == OFF_WORD0)  ? w_q[0] :
		(paddr == OFF_WORD1)  ? w_q[1] :
		(paddr == OFF_WORD2)  ? w_q[2] :
		(paddr == OFF_WORD3)  ? w_q[3] :
		(paddr == OFF_STRIDE) ? {20'h0_0000, stride_q} :
		(paddr == OFF_MISC)   ? misc_q :
		(paddr == OFF_LEAF)   ? leaf_q : 32'h0000_0000;

	// ----------------------------------------------------------------
	// APB answer: no wait state, ready in first access cycle
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready_q  <= setup;
			pslverr_q <= setup && !known;
			prdata_q  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Software writable settings
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_q   <= 32'h0000_0000;
			leaf_q    <= LEAF_CACHE;
			misc_q    <= MISC_RESET;
			misc_we_q <= 1'b0;
			det_q     <= 1'b1;
			legacy_q  <= 8'h00;
		end else if (clk_en) begin
			misc_we_q <= wr && (paddr == OFF_MISC);
			if (wr && (paddr == OFF_INDEX)) index_q <= pwdata;
			if (wr && (paddr == OFF_LEAF))  leaf_q  <= pwdata;
			if (wr && (paddr == OFF_MISC))  misc_q  <= pwdata;
			if (wr && (paddr == OFF_CTRL)) begin
				det_q    <= pwdata[1];
				legacy_q <= pwdata[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// Query sequencer; done set wins over clear by new start
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= Q_IDLE;
			done_q   <= 1'b0;
			vis_q    <= 1'b0;
			stride_q <= STRIDE_NONE;
			for (int i = 0; i < 4; i++) w_q[i] <= 32'h0000_0000;
		end else if (clk_en) begin
			unique case (st_q)
				Q_IDLE: begin
					if (go) begin
						st_q   <= Q_ASK;
						done_q <= 1'b0;
					end
				end
				Q_ASK: st_q <= Q_WAIT;
				Q_WAIT: begin
					if (link.ack) begin
						st_q     <= Q_IDLE;
						done_q   <= 1'b1;
						vis_q    <= link.visible;
						w_q[0]   <= link.word0;
						w_q[1]   <= link.word1;
						w_q[2]   <= link.word2;
						w_q[3]   <= link.word3;
						stride_q <= stride_d;
					end
				end
				default: st_q <= Q_IDLE;
			endcase
		end
	end

	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign link.req     = (st_q == Q_ASK);
	assign link.leaf    = leaf_q;
	assign link.index   = index_q;
	assign link.misc_en = misc_q;
	assign link.misc_we = misc_we_q;

endmodule : cache_query_host
`default_nettype wire

/* cache_link_checker.sv */
/*
 * Checker for the link between query side and enumerator.
 * Assumes one clock domain and an instance beside the link.
 */
`timescale 1ns/10ps
`default_nettype none
module cache_link_checker
	import cache_enum_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        req,
	input wire logic [31:0] leaf,
	input wire logic [31:0] index,
	input wire logic        ack,
	input wire logic        visible,
	input wire logic [31:0] word0,
	input wire logic [31:0] word3,
	input wire logic [31:0] misc_en
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Link rules
	// ------------------------------------------------------------
	// Hidden leaf range; limit bit is set well before a query
	wire hid = leaf > LEAF_LOW_LIMIT && leaf < LEAF_HIGH_LIMIT
		&& misc_en[LEAF_LIMIT_BIT];

	ack_after_req_a: assert property (req |=> ack)
		else $error("no ack after req");
	ack_cause_a: assert property (ack |-> $past(req))
		else $error("ack without req");
	words_hold_a: assert property (!ack |-> $stable(word0))
		else $error("word0 changed without ack");
	type_code_a: assert property (ack |-> word0[4:0] <= 5'h03)
		else $error("reserved cache type");
	level_start_a: assert property (
		ack && word0[4:0] != 5'h00 |-> word0[7:5] != 3'h0)
		else $error("level zero on live cache");
	rsvd_zero_a: assert property (
		ack |-> word0[13:10] == 4'h0 && word3 == 32'h0000_0000)
		else $error("reserved bits set");
	hidden_leaf_a: assert property (
		req && hid |=> !visible && word0 == 32'h0000_0000)
		else $error("hidden leaf answered");
	shown_leaf_a: assert property (req && !hid |=> visible)
		else $error("leaf not visible");
	null_tail_a: assert property (
		req && leaf == LEAF_CACHE && index >= 32'h0000_0003 && !hid
		|=> word0[4:0] == CT_NULL)
		else $error("live type past end");

	// Main scenarios reached
	cover property (ack && visible && word0[4:0] == CT_UNIFIED);
	cover property (req && hid);
	cover property (ack && visible && word0[4:0] == CT_NULL);
endmodule : cache_link_checker
`default_nettype wire

/* cache_parameter_enumerator_bench.sv */
/*
 * Bench: both ends joined by the link, host driven over APB.
 * Assumes pclk at 25 MHz and a single descriptor table.
 */
`timescale 1ns/10ps
`default_nettype none
module cache_parameter_enumerator_bench
	import cache_enum_pkg::*;
();
	typedef struct packed {
		logic [31:0] idx;
		logic [31:0] leaf;
		logic        lim;
		logic        vis;
		logic [31:0] w0;
		logic [31:0] w1;
		logic [31:0] w2;
		logic [11:0] pf;
	} row_type;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] st;
	logic [31:0] rd;
	logic        er;
	logic [11:0] ex;
	int          fails;
	int          n_checks;
	row_type     r;
	row_type     rows [9];

	// ------------------------------------------------------------
	// Both ends facing each other
	// ------------------------------------------------------------
	cache_query_if cache_query_if_i ();
	// Clock enable tied high; freezing is not exercised here
	cache_param_enum cache_param_enum_i (.pclk(pclk), .presetn(presetn),
		.clk_en(1'b1), .link(cache_query_if_i));
	cache_query_host cache_query_host_i (.pclk(pclk), .presetn(presetn),
		.clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(cache_query_if_i));
	cache_link_checker cache_link_checker_i (.pclk(pclk),
		.presetn(presetn), .req(cache_query_if_i.req),
		.leaf(cache_query_if_i.leaf), .index(cache_query_if_i.index),
		.ack(cache_query_if_i.ack), .visible(cache_query_if_i.visible),
		.word0(cache_query_if_i.word0), .word3(cache_query_if_i.word3),
		.misc_en(cache_query_if_i.misc_en));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task report_and_stop;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One APB transfer; answer taken at the edge that samples pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			fails++;
			report_and_stop;
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Program a query, start it, poll for done; stale done is skipped
	task run_q(input logic [31:0] i, lf, m, c);
		int k;
		k = 0;
		apb(1'b1, OFF_MISC, m);
		apb(1'b1, OFF_LEAF, lf);
		apb(1'b1, OFF_INDEX, i);
		apb(1'b1, OFF_CTRL, c);
		do begin
			apb(1'b0, OFF_STATUS, 32'h0000_0000);
			k++;
		end while ((rd[1] !== 1'b1 || k < 2) && k < 8);
		st = rd;
		if (st[1] !== 1'b1) begin
			fails++;
			report_and_stop;
		end
	endtask : run_q

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		// Geometry: 64-byte lines, 8/8/16 ways, 64/64/4096 sets,
		// two sharers, two cores; every live count stored minus one
		rows = '{
			'{32'h0000_0000, 32'h0000_0004, 1'b0, 1'b1,
				32'h0400_4121, 32'h01C0_003F, 32'h0000_003F, STRIDE_DEFAULT},
			'{32'h0000_0001, 32'h0000_0004, 1'b0, 1'b1,
				32'h0400_4122, 32'h01C0_003F, 32'h0000_003F, STRIDE_NONE},
			'{32'h0000_0002, 32'h0000_0004, 1'b0, 1'b1,
				32'h0400_4143, 32'h03C0_003F, 32'h0000_0FFF, STRIDE_128},
			'{32'h0000_0003, 32'h0000_0004, 1'b0, 1'b1,
				32'h0000_0000, 32'h0000_0000, 32'h0000_0000, STRIDE_NONE},
			'{32'h0000_001F, 32'h0000_0004, 1'b0, 1'b1,
				32'h0000_0000, 32'h0000_0000, 32'h0000_0000, STRIDE_NONE},
			'{32'h0000_0000, 32'h0000_0004, 1'b1, 1'b0,
				32'h0000_0000, 32'h0000_0000, 32'h0000_0000, STRIDE_NONE},
			'{32'h0000_0000, 32'h7FFF_FFFF, 1'b1, 1'b0,
				32'h0000_0000, 32'h0000_0000, 32'h0000_0000, STRIDE_NONE},
			'{32'h0000_0000, 32'h0000_0003, 1'b1, 1'b1,
				32'h0000_0000, 32'h0000_0000, 32'h0000_0000, STRIDE_NONE},
			'{32'h0000_0000, 32'h8000_0000, 1'b1, 1'b1,
				32'h0000_0000, 32'h0000_0000, 32'h0000_0000, STRIDE_NONE}};
		fails = 0;
		n_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Table rows, descriptor mechanism on
		for (int i = 0; i < 9; i++) begin
			r = rows[i];
			run_q(r.idx, r.leaf, {9'h000, r.lim, 22'h00_0000},
				32'h0000_0003);
			chk("visible", {31'h0, r.vis}, {31'h0, st[2]});
			apb(1'b0, OFF_WORD0, 32'h0000_0000);
			chk("type", {27'h0, r.w0[4:0]}, {27'h0, rd[4:0]});
			chk("level", {29'h0, r.w0[7:5]}, {29'h0, rd[7:5]});
			chk("rsvd", 32'h0000_0000, {28'h0, rd[13:10]});
			chk("word0", r.w0, rd);
			apb(1'b0, OFF_WORD1, 32'h0000_0000);
			chk("word1", r.w1, rd);
			apb(1'b0, OFF_WORD2, 32'h0000_0000);
			chk("word2", r.w2, rd);
			apb(1'b0, OFF_WORD3, 32'h0000_0000);
			chk("word3", 32'h0000_0000, rd);
			apb(1'b0, OFF_STRIDE, 32'h0000_0000);
			chk("stride", {20'h0, r.pf}, rd);
		end
		// Legacy codes without the descriptor mechanism
		for (int j = 0; j < 3; j++) begin
			run_q(32'h0000_0000, 32'h0000_0004, 32'h0000_0000,
				{16'h0000, (j == 0) ? LEGACY_PF_64 :
				(j == 1) ? LEGACY_PF_128 : 8'h00, 8'h01});
			ex = (j == 0) ? STRIDE_DEFAULT :
				(j == 1) ? STRIDE_128 : STRIDE_LEGACY;
			apb(1'b0, OFF_STRIDE, 32'h0000_0000);
			chk("legacy stride", {20'h0, ex}, rd);
		end
		// Unmapped and unaligned places are refused
		apb(1'b0, 12'h040, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, {31'h0, er});
		apb(1'b1, 12'h006, 32'hFFFF_FFFF);
		chk("unaligned err", 32'h0000_0001, {31'h0, er});
		// Second reset in mid-run, then reset values
		apb(1'b1, OFF_MISC, 32'h0040_0000);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_MISC, 32'h0000_0000);
		chk("misc reset", MISC_RESET, rd);
		apb(1'b0, OFF_LEAF, 32'h0000_0000);
		chk("leaf reset", LEAF_CACHE, rd);
		apb(1'b0, OFF_CTRL, 32'h0000_0000);
		chk("mechanism reset", 32'h0000_0001, {31'h0, rd[1]});
		report_and_stop;
	end
endmodule : cache_parameter_enumerator_bench
`default_nettype wire
